/* dca_top.sv */
// Top: DMA channel start-up, request latching and fixed-priority arbitration
//
// Overview of operation
// R1: A channel moves nothing until software sets its channel_enable_bit.
// R2: Disable then re-enable clears transfer count and selects the primary buffer.
// R3: Enabled channel starts a transfer on its peripheral request, no software step.
// R4: Transmit-only serial master needs a forced request or direct buffer write.
// R5: Receive-only serial master needs null-write mode and a forced request.
// R6: Full-duplex master and transmitting slave need a forced first transfer.
// R7: Receive-only serial slave requests on first data; no priming needed.
// R8: Stereo codec needs two forced transfers, left then right, before enabling.
// R9: UART transmitter requests at enable, so enable the channel first.
// R10: Transmitter request before channel enable is lost; use the manual request bit.
// R11: Fixed priority: channel 0 highest, channel 7 lowest.
// R12: Each peripheral request is latched by its channel until serviced.
// R13: Idle controller grants a requester; no other grant during a transfer.
// R14: After a transfer the highest pending channel wins, late arrivals included.
// R15: Access outside dual_port_ram stalls until the memory arbiter acknowledges.
// R16: Duplicate request while pending is ignored; cleared only at completion. The code also clears it when the enable is cleared.
// R17: Overruns flagged only on peripheral-to-memory channels.
// R18: Overrun transfer moves the latest peripheral data.
// R19: Receiver overrun handling is the peripheral's; flag is reported here.
// R20: Overrun value lands at the address meant for the lost data.
// R21: Clearing the enable discards any latched request of that channel.
`timescale 1ns/1ps
module dca_top #(
   parameter int NUM_CH = dca_pkg::NUM_CH,
   parameter int DATA_W = dca_pkg::DATA_W
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Peripheral request lines, one per channel
   input wire logic [NUM_CH-1:0] periph_req,
   // Peripheral bus
   output dca_pkg::dca_per_req_t per_out,
   input wire logic [DATA_W-1:0] per_rdata,
   // Memory side and system memory arbiter
   output dca_pkg::dca_mem_req_t mem_out,
   input wire logic [DATA_W-1:0] mem_rdata,
   input wire logic mem_ack,
   // Status
   output logic [NUM_CH-1:0] overrun,
   output logic busy
);
   localparam int CW = $clog2(NUM_CH);
   // -------------------------------------------------------------
   // Channel state
   // -------------------------------------------------------------
   logic [DATA_W-1:0] ctl [NUM_CH];
   logic [DATA_W-1:0] base_addr [NUM_CH];
   logic [DATA_W-1:0] per_addr [NUM_CH];
   logic [DATA_W-1:0] xfer_cnt [NUM_CH];
   // Ping-pong switching lives outside this block; only the primary select is kept here
   logic [NUM_CH-1:0] alt_buf;
   logic [NUM_CH-1:0] pending;
   logic [NUM_CH-1:0] forced;
   logic [NUM_CH-1:0] req_prev;
   logic [CW-1:0] cur_ch;
   logic [CW-1:0] last_ch;
   logic [DATA_W-1:0] hold_data;
   dca_pkg::dca_state_t state;
   dca_pkg::dca_state_t next_state;
   logic [NUM_CH-1:0] enabled;
   logic [NUM_CH-1:0] req_rise;
   logic [NUM_CH-1:0] done_vec;
   logic any_pend;
   logic [CW-1:0] win_ch;
   logic done;
   logic wr_hit;
   logic [CW-1:0] reg_ch;
   logic [2:0] reg_fld;

   // Lowest-numbered set bit wins
   // Scanning downwards lets the lower index overwrite, so channel 0 always tops the list
   function automatic logic [CW-1:0] first_set(input logic [NUM_CH-1:0] v);
      logic [CW-1:0] r;
      r = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = CW'(i);
         end
      end
      return r;
   endfunction

   // -------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------
   assign reg_ch = reg_addr[CW+2:3];
   assign reg_fld = reg_addr[2:0];
   // Writes above the channel window land nowhere
   assign wr_hit = reg_wr && (reg_addr < 8'(NUM_CH * 8));
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         enabled[i] = ctl[i][dca_pkg::CTL_ENABLE];
      end
   end
   // Requests count on their rising edge so a held level is one request
   // A level already high at enable is no edge, so a request raised before enable is lost
   assign req_rise = periph_req & ~req_prev & enabled; // R1 R3 R7 R9
   assign any_pend = |pending;
   assign win_ch = first_set(pending); // R11 R14
   // Completion: dual-port access is one cycle, system RAM waits for ack
   assign done = (state == dca_pkg::ST_XFER) ||
                 (state == dca_pkg::ST_STALL && mem_ack); // R15
   // One-hot completion strobe for the granted channel
   always_comb begin
      done_vec = '0;
      if (done) begin
         done_vec[cur_ch] = 1'b1;
      end
   end

   // -------------------------------------------------------------
   // Arbiter state machine
   // -------------------------------------------------------------
   // Grants come only from idle, so nothing overtakes a stalled channel
   always_comb begin
      next_state = state;
      case (state)
         dca_pkg::ST_IDLE: begin
            if (any_pend) begin
               next_state = ctl[win_ch][dca_pkg::CTL_SYSRAM] ? dca_pkg::ST_STALL : dca_pkg::ST_XFER; // R13
            end
         end
         dca_pkg::ST_XFER: next_state = dca_pkg::ST_IDLE;
         dca_pkg::ST_STALL: begin
            if (mem_ack) begin
               next_state = dca_pkg::ST_IDLE; // R15
            end
         end
         default: next_state = dca_pkg::ST_IDLE;
      endcase
   end

   // State register and granted channel
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= dca_pkg::ST_IDLE;
         cur_ch <= '0;
         last_ch <= '0;
      end else begin
         state <= next_state;
         if (state == dca_pkg::ST_IDLE && any_pend) begin
            cur_ch <= win_ch; // R13 R14
         end
         if (done) begin
            last_ch <= cur_ch;
         end
      end
   end

   // -------------------------------------------------------------
   // Request latches
   // -------------------------------------------------------------
   // Peripheral edges set, completion clears; a new edge beats the clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pending <= '0;
         forced <= '0;
         req_prev <= '0;
         overrun <= '0;
      end else begin
         req_prev <= periph_req;
         for (int i = 0; i < NUM_CH; i++) begin
            // Software clear goes first so that an overrun in the same cycle still sets the flag
            if (wr_hit && reg_ch == CW'(i) && reg_fld == dca_pkg::OFF_STATUS &&
                reg_wdata[dca_pkg::ST_OVERRUN]) begin
               overrun[i] <= 1'b0;
            end
            if (!enabled[i]) begin
               pending[i] <= 1'b0; // R21
               forced[i] <= 1'b0;
            end else if (req_rise[i]) begin
               pending[i] <= 1'b1; // R12 R16
               if (pending[i] && !done_vec[i] && ctl[i][dca_pkg::CTL_DIR_P2M]) begin
                  overrun[i] <= 1'b1; // R17 R19
               end
            end else if (done_vec[i]) begin
               pending[i] <= 1'b0; // R16
               forced[i] <= 1'b0;
            end
            // Manual request: ignored while one is pending or in flight
            // A force that meets a peripheral edge is dropped; the peripheral request proceeds
            if (wr_hit && reg_ch == CW'(i) && reg_fld == dca_pkg::OFF_REQSEL &&
                reg_wdata[dca_pkg::REQ_FORCE] && enabled[i] && !pending[i] && !req_rise[i]) begin
               pending[i] <= 1'b1; // R4 R5 R6 R8 R10
               forced[i] <= 1'b1;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Channel configuration, count and buffer select
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_CH; i++) begin
            ctl[i] <= dca_pkg::CTL_RESET;
            base_addr[i] <= '0;
            per_addr[i] <= '0;
            xfer_cnt[i] <= dca_pkg::CNT_RESET;
         end
         alt_buf <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (done_vec[i]) begin
               xfer_cnt[i] <= xfer_cnt[i] + 1'b1;
            end
            if (wr_hit && reg_ch == CW'(i)) begin
               case (reg_fld)
                  dca_pkg::OFF_CONTROL: begin
                     ctl[i] <= reg_wdata;
                     if (reg_wdata[dca_pkg::CTL_ENABLE] && !enabled[i]) begin
                        xfer_cnt[i] <= dca_pkg::CNT_RESET; // R2
                        alt_buf[i] <= 1'b0;
                     end
                  end
                  dca_pkg::OFF_ADDR: base_addr[i] <= reg_wdata;
                  dca_pkg::OFF_PERIPH: per_addr[i] <= reg_wdata;
                  default: ;
               endcase
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Data path
   // -------------------------------------------------------------
   // Peripheral data is sampled at grant, after any duplicate edge raised while waiting, so the latest (overrun) value moves
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         per_out <= '0;
         mem_out <= '0;
         hold_data <= '0;
         busy <= 1'b0;
      end else begin
         per_out <= '0;
         // Follows next_state so that it rises with the grant and falls with completion
         busy <= (next_state != dca_pkg::ST_IDLE);
         if (state == dca_pkg::ST_IDLE && any_pend) begin
            mem_out.valid <= 1'b1;
            mem_out.write <= ctl[win_ch][dca_pkg::CTL_DIR_P2M];
            mem_out.sysram <= ctl[win_ch][dca_pkg::CTL_SYSRAM];
            // Count-indexed slot: overrun data lands where lost data belonged
            mem_out.addr <= base_addr[win_ch] + xfer_cnt[win_ch]; // R20
            mem_out.data <= per_rdata; // R18
            // Dual-port outbound word is fetched at grant, needing no wait; a system RAM word is taken at completion
            hold_data <= mem_rdata;
         end else if (done) begin
            mem_out <= '0;
            per_out.addr <= per_addr[cur_ch];
            if (ctl[cur_ch][dca_pkg::CTL_DIR_P2M]) begin
               per_out.rd <= 1'b1;
               per_out.wr <= ctl[cur_ch][dca_pkg::CTL_NULLW] && !forced[cur_ch];
               per_out.data <= '0;
            end else begin
               per_out.wr <= 1'b1; // R17
               per_out.data <= mem_out.sysram ? mem_rdata : hold_data;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Register read port
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         // Data stand one cycle and are zero otherwise, so a stale word is never mistaken
         if (reg_rd) begin
            if (reg_addr == dca_pkg::OFF_GLOBAL) begin
               reg_rdata <= {busy, {(DATA_W-1-CW){1'b0}}, last_ch};
            end else if (reg_addr < 8'(NUM_CH * 8)) begin
               case (reg_fld)
                  dca_pkg::OFF_CONTROL: begin
                     reg_rdata <= ctl[reg_ch];
                     reg_rdata[dca_pkg::CTL_ALTBUF] <= alt_buf[reg_ch];
                  end
                  dca_pkg::OFF_REQSEL: reg_rdata <= {forced[reg_ch], {(DATA_W-1){1'b0}}};
                  dca_pkg::OFF_ADDR: reg_rdata <= base_addr[reg_ch];
                  dca_pkg::OFF_COUNT: reg_rdata <= xfer_cnt[reg_ch];
                  dca_pkg::OFF_PERIPH: reg_rdata <= per_addr[reg_ch];
                  dca_pkg::OFF_STATUS: reg_rdata <= {{(DATA_W-2){1'b0}}, overrun[reg_ch], pending[reg_ch]};
                  default: reg_rdata <= '0;
               endcase
            end
         end
      end
   end
endmodule

/* dca_pkg.sv */
// Package: constants, register offsets and carrier types of the DMA channel arbiter
package dca_pkg;
   // Channel count and data width defaults
   localparam int NUM_CH = 8;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 16;
   // -------------------------------------------------------------
   // Register offsets (word index = channel * CH_STRIDE + field)
   // -------------------------------------------------------------
   localparam logic [7:0] CH_STRIDE = 8'h08;
   localparam logic [2:0] OFF_CONTROL = 3'h0; // channel_control_reg
   localparam logic [2:0] OFF_REQSEL = 3'h1;  // request_select_reg
   localparam logic [2:0] OFF_ADDR = 3'h2;
   localparam logic [2:0] OFF_COUNT = 3'h3;
   localparam logic [2:0] OFF_PERIPH = 3'h4;
   localparam logic [2:0] OFF_STATUS = 3'h5;
   localparam logic [7:0] OFF_GLOBAL = 8'h40; // Last channel and busy
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int CTL_ENABLE = 0;   // channel_enable_bit
   localparam int CTL_DIR_P2M = 1;  // 1: peripheral to memory
   localparam int CTL_NULLW = 2;    // Null data write on peripheral reads
   localparam int CTL_SYSRAM = 3;   // Buffer lies outside dual_port_ram
   localparam int CTL_ALTBUF = 4;   // Read-only: secondary buffer active
   localparam int REQ_FORCE = 15;   // Manual request bit
   localparam int ST_PENDING = 0;
   localparam int ST_OVERRUN = 1;
   // Reset values
   localparam logic [DATA_W-1:0] CTL_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] CNT_RESET = 16'h0000;
   // Memory transfer request to the system side
   typedef struct packed {
      logic valid;
      logic write;
      logic sysram;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } dca_mem_req_t;
   // Peripheral bus access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } dca_per_req_t;
   // Arbiter states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_XFER = 3'b010,
      ST_STALL = 3'b100
   } dca_state_t;
endpackage

/* dca_top_sva.sv */
// Checker: port-level timing of transfers, completions, status flags and read data
`timescale 1ns/1ps
module dca_top_sva #(
   parameter int NUM_CH = 8,
   parameter int DATA_W = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Data movement
   input wire logic [NUM_CH-1:0] periph_req,
   input wire dca_pkg::dca_per_req_t per_out,
   input wire logic [DATA_W-1:0] per_rdata,
   input wire dca_pkg::dca_mem_req_t mem_out,
   input wire logic [DATA_W-1:0] mem_rdata,
   input wire logic mem_ack,
   // Status
   input wire logic [NUM_CH-1:0] overrun,
   input wire logic busy
);
   logic [NUM_CH-1:0] p2m_on;
   wire logic done = per_out.rd | per_out.wr;
   // Mirror of enable and direction; only enabled inbound channels may flag an overrun
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         p2m_on <= '0;
      end else if (reg_wr && reg_addr[7:6] == 2'b00 && reg_addr[2:0] == dca_pkg::OFF_CONTROL) begin
         p2m_on[reg_addr[5:3]] <= reg_wdata[dca_pkg::CTL_DIR_P2M] & reg_wdata[dca_pkg::CTL_ENABLE];
      end
   end
   // One clock domain, so clocking and reset are given once
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_VALID_BUSY: assert property (mem_out.valid |-> busy) else $error("transfer without busy");
   AST_DP_DONE: assert property ($rose(mem_out.valid) && !mem_out.sysram |=> done && !mem_out.valid)
      else $error("dual-port transfer did not finish in one cycle");
   AST_STALL_HOLD: assert property (mem_out.valid && mem_out.sysram && !mem_ack |=> mem_out.valid && $stable(mem_out.addr))
      else $error("stalled transfer released early");
   AST_ACK_DONE: assert property (mem_out.valid && mem_out.sysram && mem_ack |=> done)
      else $error("acknowledged transfer did not complete");
   AST_GAP: assert property ($fell(mem_out.valid) |-> !busy && done)
      else $error("no idle cycle after a transfer");
   AST_PULSE_ONE: assert property (done |=> !done) else $error("completion pulse too long");
   AST_PULSE_CAUSE: assert property (done |-> $past(mem_out.valid)) else $error("completion without transfer");
   AST_OVR_P2M: assert property ((overrun & ~$past(overrun) & ~p2m_on) == '0)
      else $error("overrun on a channel that is not inbound");
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0) else $error("read data outside slot");
endmodule

/* dca_far_model.sv */
// Far-side model: a peripheral data register and the system memory arbiter
`timescale 1ns/1ps
module dca_far_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Arbiter wait, set by the bench
   input wire logic [7:0] stall_cycles,
   // Design side
   input wire dca_pkg::dca_mem_req_t mem_out,
   output logic [15:0] per_rdata,
   output logic [15:0] mem_rdata,
   output logic mem_ack
);
   logic [15:0] pat = 16'h5A00;
   logic ack_q = 1'b0;
   int waited = 0;
   // Data changes every cycle so that a stale sample can never look right
   assign per_rdata = pat;
   assign mem_rdata = ~pat;
   assign mem_ack = ack_q;
   // Arbiter grants once, a set number of cycles after an outside access starts
   always @(posedge sys_clk) begin
      pat <= pat + 16'h0001;
      if (rst || !mem_out.valid || !mem_out.sysram) begin
         waited <= 0;
         ack_q <= 1'b0;
      end else begin
         ack_q <= (waited == int'(stall_cycles));
         waited <= waited + 1;
      end
   end
endmodule

/* tb.sv */
// Testbench: start-up, priority, stall and overrun scenarios against a queue model
`timescale 1ns/1ps
module tb;
   localparam int NUM_CH = dca_pkg::NUM_CH;
   localparam int DATA_W = dca_pkg::DATA_W;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [DATA_W-1:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [NUM_CH-1:0] periph_req = 8'h00;
   logic [7:0] stall = 8'h02;
   logic [DATA_W-1:0] reg_rdata, per_rdata, mem_rdata;
   dca_pkg::dca_per_req_t per_out;
   dca_pkg::dca_mem_req_t mem_out;
   logic mem_ack, busy;
   logic [NUM_CH-1:0] overrun;
   logic [15:0] cap_addr = 16'h0000;
   logic [15:0] rv;
   logic [7:0] m;
   logic [15:0] cap_data = 16'h0000;
   logic [15:0] exp_data = 16'h0000;
   logic [15:0] last_per = 16'h0000;
   logic vq = 1'b0;
   int e;
   int errors = 0;
   int checks_done = 0;
   int seed = 89;
   int mch;
   int exp_q[$];
   int cnt[8] = '{default: 0};
   always #20 sys_clk = ~sys_clk;
   dca_top #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) dut_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req),
      .per_out(per_out), .per_rdata(per_rdata), .mem_out(mem_out), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
      .overrun(overrun), .busy(busy));
   dca_far_model far_u (.sys_clk(sys_clk), .rst(rst), .stall_cycles(stall), .mem_out(mem_out),
      .per_rdata(per_rdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin errors++; $display("CHECK FAILED %0t register %h not %h", $time, got, exp); end
   endtask
   task automatic chk_xfer(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin errors++; $display("CHECK FAILED %0t transfer %h not %h", $time, got, exp); end
   endtask
   task automatic chk_flag(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin errors++; $display("CHECK FAILED %0t flags %h not %h", $time, got, exp); end
   endtask
   // Bus cycles: one-cycle strobes, an idle cycle between them keeps each strobe driven once per step
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge sys_clk); reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge sys_clk); reg_addr <= a; reg_rd <= 1'b1;
      @(posedge sys_clk); reg_rd <= 1'b0;
      @(posedge sys_clk); d = reg_rdata;
   endtask
   task automatic pulse(input logic [7:0] v);
      @(posedge sys_clk); periph_req <= periph_req | v;
      @(posedge sys_clk); periph_req <= periph_req & ~v;
   endtask
   // Bounded wait until the model has seen every expected completion
   task automatic wait_done();
      int n;
      n = 0;
      repeat (10) @(posedge sys_clk);
      while ((exp_q.size() != 0 || busy !== 1'b0) && n < 400) begin @(posedge sys_clk); n++; end
      chk_reg(16'(exp_q.size()), 16'h0000);
   endtask
   task automatic wrap_up();
      $display("Checks done %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Scoreboard: each completion is the model's next channel, at its base plus its count
   always @(posedge sys_clk) begin
      // Grant samples the peripheral word of the previous cycle; entries above 15 expect a null write
      if (!rst && mem_out.valid === 1'b1) begin
         if (!vq) exp_data = last_per;
         cap_addr = mem_out.addr;
         cap_data = mem_out.data;
      end
      vq = (mem_out.valid === 1'b1);
      last_per = per_rdata;
      if (!rst && (per_out.rd | per_out.wr) === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk_xfer(per_out.addr, 16'hFFFF);
         end else begin
            e = exp_q.pop_front();
            mch = e % 16;
            chk_xfer(per_out.addr, 16'h0100 + 16'(mch));
            chk_xfer(cap_addr, 16'(mch << 8) + 16'(cnt[mch]));
            chk_flag({6'h00, per_out.wr, per_out.rd}, (mch == 3) ? 8'h02 : ((e > 15) ? 8'h03 : 8'h01));
            if (mch == 3) chk_xfer(per_out.data, ~exp_data);
            else chk_xfer(cap_data, exp_data);
            cnt[mch]++;
         end
      end
   end
   // Main sequence; channel 1 lies outside the dual-port RAM, channel 3 is outbound
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      rd(8'h00, rv); chk_reg(rv, dca_pkg::CTL_RESET);
      rd(8'h03, rv); chk_reg(rv, dca_pkg::CNT_RESET);
      wr(8'h3F, 16'hFFFF);
      rd(8'h38, rv); chk_reg(rv, dca_pkg::CTL_RESET);
      periph_req[7] <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         wr(8'(c * 8 + 4), 16'h0100 + 16'(c));
         wr(8'(c * 8 + 2), 16'(c << 8));
         wr(8'(c * 8), {12'h000, c == 1, 1'b0, c != 3, 1'b1});
      end
      wait_done();
      periph_req[7] <= 1'b0;
      wr(8'h39, 16'h8000); exp_q.push_back(7); wait_done();
      repeat (2) begin wr(8'h31, 16'h8000); exp_q.push_back(6); wait_done(); end
      repeat (4) begin
         m = 8'($random(seed));
         for (int c = 0; c < 8; c++) if (m[c]) exp_q.push_back(c);
         pulse(m); wait_done();
      end
      // Long stall on channel 1 while higher, duplicate and withdrawn requests arrive
      stall <= 8'h14;
      exp_q = '{1, 0, 2, 3};
      pulse(8'h42); pulse(8'h01); pulse(8'h1C); pulse(8'h0C);
      wr(8'h20, 16'h0000); wr(8'h20, 16'h0003); cnt[4] = 0;
      exp_q.push_back(6);
      wait_done();
      chk_flag(overrun, 8'h04);
      rd(8'h13, rv); chk_reg(rv, 16'(cnt[2]));
      rd(8'h23, rv); chk_reg(rv, 16'h0000);
      rd(8'h20, rv); chk_reg(rv, 16'h0003);
      rd(8'h15, rv); chk_reg(rv, 16'h0002);
      wr(8'h15, 16'h0002); rd(8'h15, rv); chk_reg(rv, 16'h0000); chk_flag(overrun, 8'h00);
      // Receive channel with null writes: forced first word, then a peripheral request
      wr(8'h28, 16'h0007); wr(8'h29, 16'h8000); exp_q.push_back(5); wait_done();
      exp_q.push_back(21); pulse(8'h20); wait_done();
      rd(8'h40, rv); chk_reg(rv, 16'h0005);
      wrap_up();
   end
   // Watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      wrap_up();
   end
endmodule
bind dca_top dca_top_sva #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) chk_u (.sys_clk(sys_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .periph_req(periph_req), .per_out(per_out), .per_rdata(per_rdata), .mem_out(mem_out),
   .mem_rdata(mem_rdata), .mem_ack(mem_ack), .overrun(overrun), .busy(busy));
